// file: mcz_pkg.sv
// How it works
// - Shift-enable write shifts 40-bit accumulator once
// - Shift-enable also gates DMA multi-bit shifts
// - Direction bit: 0 left, 1 right
// - Clear zeroes accumulator, MCU mode only
// - Clear resets status except interrupt, ready
// - Clear bit self-clears, always reads zero
// - Fractional bit: 0 integer, 1 fractional
// - Accumulate bit: 0 MAC, 1 multiply-only
// - Accumulator negate before adding product
// - B negate feeds negated B, register unchanged
// - A negate feeds negated A, register unchanged
// - Register at 0xC0 page 0xF, bit-addressable
// - MCU start runs one operation, busy clears
// - Signed enable picks signed or unsigned arithmetic
`default_nettype none
package mcz_pkg;
  localparam int unsigned MCZ_ACC_W = 40;
  localparam int unsigned MCZ_OP_W = 16;
  localparam logic [3:0] MCZ_SFR_PAGE = 4'hF;
  localparam logic [7:0] MCZ_CFG0_ADDR = 8'hC0;
  localparam logic [7:0] MCZ_CFG0_RESET = 8'h00;
  localparam int unsigned MCZ_B_SHIFT_EN = 7;
  localparam int unsigned MCZ_B_SHIFT_DIR = 6;
  localparam int unsigned MCZ_B_CLR_ACC = 5;
  localparam int unsigned MCZ_B_FRAC = 4;
  localparam int unsigned MCZ_B_ACC_MODE = 3;
  localparam int unsigned MCZ_B_ACC_NEG = 2;
  localparam int unsigned MCZ_B_NEG_B = 1;
  localparam int unsigned MCZ_B_NEG_A = 0;
  // Bits that read back; the two write-only triggers read as zero
  localparam logic [7:0] MCZ_CFG0_RD_MASK = 8'h5F;
  localparam logic [2:0] MCZ_SINGLE_SHIFT = 3'h1;
  localparam logic [7:0] MCZ_FULL_MASK = 8'hFF;
  localparam logic [7:0] MCZ_ONE_BIT = 8'h01;
endpackage
`default_nettype wire

// file: mcz_mul_if.sv
`default_nettype none
interface mcz_mul_if;
  import mcz_pkg::*;
  logic [MCZ_OP_W-1:0] op_a;
  logic [MCZ_OP_W-1:0] op_b;
  logic neg_a;
  logic neg_b;
  logic signed_en;
  logic frac;
  logic [MCZ_ACC_W-1:0] product;
  modport user (output op_a, op_b, neg_a, neg_b, signed_en, frac, input product);
  modport mult (input op_a, op_b, neg_a, neg_b, signed_en, frac, output product);
endinterface
`default_nettype wire

// file: mcz_mul.sv
`default_nettype none
module mcz_mul
  import mcz_pkg::*;
(
  mcz_mul_if.mult mul // Operands in, extended product out
);
  logic signed [MCZ_OP_W:0] ax;
  logic signed [MCZ_OP_W:0] bx;
  logic signed [2*MCZ_OP_W+1:0] p;
  logic [MCZ_ACC_W-1:0] p_ext;

  always_comb begin
    // Extra bit keeps unsigned operands positive until negated
    ax = mul.signed_en ? {mul.op_a[MCZ_OP_W-1], mul.op_a} : {1'b0, mul.op_a};
    bx = mul.signed_en ? {mul.op_b[MCZ_OP_W-1], mul.op_b} : {1'b0, mul.op_b};
    if (mul.neg_a) begin
      ax = -ax;
    end
    if (mul.neg_b) begin
      bx = -bx;
    end
    p = ax * bx;
    p_ext = {{(MCZ_ACC_W-2*MCZ_OP_W-2){p[2*MCZ_OP_W+1]}}, p};
    // Fractional results are aligned one place up
    mul.product = mul.frac ? {p_ext[MCZ_ACC_W-2:0], 1'b0} : p_ext;
  end
endmodule
`default_nettype wire

// file: mcz_top.sv
`default_nettype none
module mcz_top
  import mcz_pkg::*;
(
  input wire logic core_clk_i, // Core clock, 10 MHz
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [3:0] sfr_page_i, // SFR page of access
  input wire logic [7:0] sfr_addr_i, // SFR address
  input wire logic sfr_wr_i, // Byte write strobe
  input wire logic [7:0] sfr_wdata_i, // Byte write data
  input wire logic sfr_bit_wr_i, // Single-bit write strobe
  input wire logic [2:0] sfr_bit_sel_i, // Bit index for bit write
  input wire logic sfr_bit_val_i, // Bit value for bit write
  input wire logic sfr_rd_i, // Read strobe
  output logic [7:0] sfr_rdata_o, // Read data, registered
  input wire logic [MCZ_OP_W-1:0] operand_a_i, // Stored A register
  input wire logic [MCZ_OP_W-1:0] operand_b_i, // Stored B register
  input wire logic start_i, // Start request, MCU mode
  input wire logic dma_mode_i, // High in DMA mode
  input wire logic dma_step_i, // One DMA operation pulse
  input wire logic signed_mode_enable_i, // Signed arithmetic
  input wire logic [1:0] mb_shift_i, // Multi-bit shift count minus one
  input wire logic flag_clr_i, // Clears ready and interrupt flags
  output logic [MCZ_ACC_W-1:0] acc_o, // Accumulator
  output logic busy_o, // Operation in progress
  output logic zero_flag_o, // Sticky: some result was zero since the last clear
  output logic result_ready_flag_o, // Result ready, MCU mode
  output logic mac_interrupt_flag_o, // Interrupt flag
  output logic status_clear_o // Pulse: status reset by clear
);

  ////////////////////////////////////////////////////////////////////////////
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic cfg_hit(input logic [3:0] page, input logic [7:0] addr);
    return (page == MCZ_SFR_PAGE) && (addr == MCZ_CFG0_ADDR);
  endfunction

  function automatic logic [MCZ_ACC_W-1:0] acc_shift(input logic [MCZ_ACC_W-1:0] v,
      input logic right, input logic sgn, input logic [2:0] n);
    if (!right) begin
      return v << n;
    end else if (sgn) begin
      return MCZ_ACC_W'($signed(v) >>> n);
    end else begin
      return v >> n;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] cfg_q, cfg_d;
  logic clr_pend_q, clr_pend_d;
  logic shot_q, shot_d;
  logic [7:0] rdata_q, rdata_d;
  logic [MCZ_ACC_W-1:0] acc_q, acc_d;
  logic busy_q, busy_d;
  logic zero_q, zero_d;
  logic ready_q, ready_d;
  logic int_q, int_d;
  logic wr_any;
  logic [7:0] wmask;
  logic [7:0] wbits;
  logic op_go;
  logic [MCZ_ACC_W-1:0] addend;
  logic [MCZ_ACC_W-1:0] result;
  mcz_mul_if mul_if ();

  mcz_mul u_mul (
    .mul(mul_if.mult)
  );

  always_comb begin
    mul_if.op_a = operand_a_i;
    mul_if.op_b = operand_b_i;
    mul_if.neg_a = cfg_q[MCZ_B_NEG_A];
    mul_if.neg_b = cfg_q[MCZ_B_NEG_B];
    mul_if.signed_en = signed_mode_enable_i;
    mul_if.frac = cfg_q[MCZ_B_FRAC];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register access
  always_comb begin
    wr_any = (sfr_wr_i || sfr_bit_wr_i) && cfg_hit(sfr_page_i, sfr_addr_i);
    wmask = sfr_bit_wr_i ? (MCZ_ONE_BIT << sfr_bit_sel_i) : MCZ_FULL_MASK;
    wbits = sfr_bit_wr_i ? ({8{sfr_bit_val_i}} & wmask) : sfr_wdata_i;
    cfg_d = cfg_q;
    clr_pend_d = 1'b0;
    shot_d = 1'b0;
    rdata_d = rdata_q;
    if (wr_any) begin
      cfg_d = (cfg_q & ~wmask) | (wbits & wmask);
      // Clear request is a one-shot; never stored in the register
      cfg_d[MCZ_B_CLR_ACC] = 1'b0;
      clr_pend_d = wbits[MCZ_B_CLR_ACC] && wmask[MCZ_B_CLR_ACC] && !dma_mode_i;
      shot_d = wbits[MCZ_B_SHIFT_EN] && wmask[MCZ_B_SHIFT_EN];
    end
    if (sfr_rd_i && cfg_hit(sfr_page_i, sfr_addr_i)) begin
      rdata_d = cfg_q & MCZ_CFG0_RD_MASK;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q <= MCZ_CFG0_RESET;
      clr_pend_q <= 1'b0;
      shot_q <= 1'b0;
      rdata_q <= MCZ_CFG0_RESET;
    end else begin
      cfg_q <= cfg_d;
      clr_pend_q <= clr_pend_d;
      shot_q <= shot_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath; clear beats operation beats single shift
  always_comb begin
    op_go = busy_q || (dma_mode_i && dma_step_i);
    addend = cfg_q[MCZ_B_ACC_NEG] ? MCZ_ACC_W'(-acc_q) : acc_q;
    result = cfg_q[MCZ_B_ACC_MODE] ? mul_if.product : addend + mul_if.product;
    if (dma_mode_i && dma_step_i && cfg_q[MCZ_B_SHIFT_EN]) begin
      result = acc_shift(result, cfg_q[MCZ_B_SHIFT_DIR], signed_mode_enable_i,
                         {1'b0, mb_shift_i} + MCZ_SINGLE_SHIFT);
    end
    acc_d = acc_q;
    busy_d = busy_q;
    zero_d = zero_q;
    ready_d = ready_q;
    int_d = int_q;
    if (flag_clr_i) begin
      ready_d = 1'b0;
      int_d = 1'b0;
    end
    if (clr_pend_q) begin
      acc_d = '0;
      busy_d = 1'b0;
      zero_d = 1'b0;
    end else if (op_go) begin
      acc_d = result;
      zero_d = (result == '0) || zero_q;
      busy_d = 1'b0;
      if (busy_q) begin
        // Set wins over a simultaneous software clear
        ready_d = 1'b1;
        int_d = 1'b1;
      end
    end else if (shot_q) begin
      acc_d = acc_shift(acc_q, cfg_q[MCZ_B_SHIFT_DIR], signed_mode_enable_i,
                        MCZ_SINGLE_SHIFT);
    end
    if (start_i && !dma_mode_i && !clr_pend_q) begin
      busy_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      acc_q <= '0;
      busy_q <= 1'b0;
      zero_q <= 1'b0;
      ready_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      busy_q <= busy_d;
      zero_q <= zero_d;
      ready_q <= ready_d;
      int_q <= int_d;
    end
  end

  assign sfr_rdata_o = rdata_q;
  assign acc_o = acc_q;
  assign busy_o = busy_q;
  assign zero_flag_o = zero_q;
  assign result_ready_flag_o = ready_q;
  assign mac_interrupt_flag_o = int_q;
  assign status_clear_o = clr_pend_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_q);

  logic clr_wr;
  assign clr_wr = wr_any && wbits[MCZ_B_CLR_ACC] && wmask[MCZ_B_CLR_ACC];

  a_clr_zeroes_acc: assert property (clr_wr && !dma_mode_i |-> ##2 acc_q == '0)
    else $error("Accumulator not zero after clear");
  a_clr_dma_ignored: assert property (clr_wr && dma_mode_i |=> !clr_pend_q)
    else $error("Clear acted in DMA mode");
  a_clr_status_kept: assert property (clr_pend_q && !flag_clr_i
      |=> !zero_q && !busy_q && ready_q == $past(ready_q) && int_q == $past(int_q))
    else $error("Clear touched wrong status bits");
  a_clr_self_clear: assert property (clr_pend_q && !clr_wr |=> !clr_pend_q)
    else $error("Clear request did not self-clear");
  a_clr_reads_zero: assert property (sfr_rdata_o[MCZ_B_CLR_ACC] == 1'b0)
    else $error("Clear bit read back as one");
  a_shift_left: assert property (shot_q && !clr_pend_q && !op_go && !cfg_q[MCZ_B_SHIFT_DIR]
      |=> acc_q == {$past(acc_q[MCZ_ACC_W-2:0]), 1'b0})
    else $error("Single left shift wrong");
  a_shift_right: assert property (shot_q && !clr_pend_q && !op_go && cfg_q[MCZ_B_SHIFT_DIR]
      && !signed_mode_enable_i |=> acc_q == {1'b0, $past(acc_q[MCZ_ACC_W-1:1])})
    else $error("Single right shift wrong");
  a_mult_only: assert property (busy_q && !clr_pend_q && cfg_q[MCZ_B_ACC_MODE]
      |=> acc_q == $past(mul_if.product))
    else $error("Multiply-only result wrong");
  a_mac_negate: assert property (busy_q && !clr_pend_q && !cfg_q[MCZ_B_ACC_MODE]
      && cfg_q[MCZ_B_ACC_NEG] |=> acc_q == MCZ_ACC_W'($past(mul_if.product) - $past(acc_q)))
    else $error("Negated accumulate wrong");
  a_busy_single_op: assert property (start_i && !dma_mode_i && !clr_pend_q
      |=> busy_q ##1 (!busy_q || $past(start_i)) && ready_q)
    else $error("Start did not complete in one op");
  a_reg_unchanged: assert property (busy_q && cfg_q[MCZ_B_NEG_A] |-> mul_if.op_a == operand_a_i)
    else $error("A operand altered");

  c_mcu_op: cover property (start_i ##1 busy_q ##1 ready_q);
  c_clear: cover property (clr_wr ##2 acc_q == '0);
  c_dma_shift: cover property (dma_mode_i && dma_step_i && cfg_q[MCZ_B_SHIFT_EN]);
  c_single_shift: cover property (shot_q && !op_go);
endmodule
`default_nettype wire

// file: tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mcz_pkg::*;
  typedef struct {int k; logic [39:0] v;} mcz_note_t;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, sfr_wr_i = 1'b0, sfr_bit_wr_i = 1'b0;
  logic sfr_bit_val_i = 1'b0, sfr_rd_i = 1'b0, start_i = 1'b0, dma_mode_i = 1'b0;
  logic dma_step_i = 1'b0, signed_mode_enable_i = 1'b0, flag_clr_i = 1'b0;
  logic [3:0] sfr_page_i = 4'hF;
  logic [7:0] sfr_addr_i = 8'hC0, sfr_wdata_i = 8'h00, cfg = 8'h00, tmp;
  logic [2:0] sfr_bit_sel_i = 3'h0;
  logic [1:0] mb_shift_i = 2'h0;
  logic [15:0] operand_a_i = 16'h0000, operand_b_i = 16'h0000;
  logic [7:0] sfr_rdata_o;
  logic [39:0] acc_o, accm = 40'h0, seen;
  logic busy_o, zero_flag_o, result_ready_flag_o, mac_interrupt_flag_o, status_clear_o;
  int failures = 0, compares = 0, cycles = 0;
  string names[7] = '{"rdata", "acc", "busy", "ready", "zero", "irq", "sclr"};
  mcz_note_t q[$];
  mcz_note_t n;

  mcz_top i_dut (.core_clk_i, .rst_n_i, .sfr_page_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
    .sfr_bit_wr_i, .sfr_bit_sel_i, .sfr_bit_val_i, .sfr_rd_i, .sfr_rdata_o, .operand_a_i,
    .operand_b_i, .start_i, .dma_mode_i, .dma_step_i, .signed_mode_enable_i, .mb_shift_i,
    .flag_clr_i, .acc_o, .busy_o, .zero_flag_o, .result_ready_flag_o, .mac_interrupt_flag_o,
    .status_clear_o);

  always #50 core_clk_i = ~core_clk_i;

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic cmp(string nm, logic [39:0] s, logic [39:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask

  // Sampled mid-cycle so every output has settled; one note per cycle at most
  always @(negedge core_clk_i) begin
    if (q.size() > 0) begin
      n = q.pop_front();
      case (n.k)
        0: seen = {32'h0, sfr_rdata_o};
        1: seen = acc_o;
        2: seen = {39'h0, busy_o};
        3: seen = {39'h0, result_ready_flag_o};
        4: seen = {39'h0, zero_flag_o};
        5: seen = {39'h0, mac_interrupt_flag_o};
        default: seen = {39'h0, status_clear_o};
      endcase
      cmp(names[n.k], seen, n.v);
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [39:0] prod(logic [15:0] a, logic [15:0] b);
    logic signed [16:0] ea, eb;
    logic signed [33:0] p;
    ea = signed_mode_enable_i ? {a[15], a} : {1'b0, a};
    eb = signed_mode_enable_i ? {b[15], b} : {1'b0, b};
    if (cfg[0]) ea = -ea;
    if (cfg[1]) eb = -eb;
    p = ea * eb;
    prod = {{6{p[33]}}, p} << cfg[4];
  endfunction

  function automatic logic [39:0] res();
    res = (cfg[3] ? 40'h0 : (cfg[2] ? -accm : accm)) + prod(operand_a_i, operand_b_i);
  endfunction

  function automatic logic [39:0] sh(logic [39:0] v, logic r, int k);
    if (!r) return v << k;
    return signed_mode_enable_i ? 40'($signed(v) >>> k) : v >> k;
  endfunction

  task automatic cyc;
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic note(int k, logic [39:0] v);
    q.push_back('{k, v});
    cyc();
  endtask

  task automatic wr8(logic [7:0] d);
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    cyc();
    sfr_wr_i = 1'b0;
    cfg = d & 8'hDF;
    if (d[7]) accm = sh(accm, d[6], 1);
    if (d[5] && !dma_mode_i) accm = 40'h0;
    note(6, 40'(d[5] && !dma_mode_i));
    cyc();
  endtask

  task automatic bw(int i, logic v);
    sfr_bit_sel_i = 3'(i);
    sfr_bit_val_i = v;
    sfr_bit_wr_i = 1'b1;
    cyc();
    sfr_bit_wr_i = 1'b0;
    cfg[i] = v;
    if (i == 7 && v) accm = sh(accm, cfg[6], 1);
    repeat (2) cyc();
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    cyc();
    sfr_rd_i = 1'b0;
    sfr_addr_i = 8'hC0;
    cyc();
    note(0, {32'h0, e});
  endtask

  task automatic op(logic [15:0] am = 16'hFFFF);
    operand_a_i = 16'($urandom) & am;
    operand_b_i = 16'($urandom);
    start_i = 1'b1;
    cyc();
    start_i = 1'b0;
    note(2, 40'(!dma_mode_i));
    if (!dma_mode_i) accm = res();
    note(1, accm);
    note(2, 40'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(40));
    repeat (10) cyc();
    rst_n_i = 1'b1;
    repeat (3) cyc();
    rd(8'hC0, 8'h00);
    for (int i = 0; i < 16; i++) begin
      signed_mode_enable_i = 1'($urandom);
      tmp = 8'($urandom) & 8'h5F;
      if (!signed_mode_enable_i) tmp[2] = 1'b0;
      wr8(tmp);
      op();
    end
    note(3, 40'h1);
    rd(8'hC0, cfg & 8'h5F);
    rd(8'hC4, cfg & 8'h5F);
    // Write on a foreign page must leave the register alone
    sfr_page_i = 4'h0;
    sfr_wdata_i = ~cfg & 8'h5F;
    sfr_wr_i = 1'b1;
    cyc();
    sfr_wr_i = 1'b0;
    sfr_page_i = 4'hF;
    rd(8'hC0, cfg & 8'h5F);
    wr8(8'h80 | (cfg & 8'h1F));
    note(1, accm);
    wr8(8'hC0 | (cfg & 8'h1F));
    note(1, accm);
    bw(6, 1'b0);
    bw(7, 1'b1);
    note(1, accm);
    rd(8'hC0, cfg & 8'h5F);
    dma_mode_i = 1'b1;
    op();
    for (int j = 0; j < 5; j++) begin
      if (j == 4) bw(7, 1'b0);
      else bw(6, 1'(j));
      mb_shift_i = 2'(j);
      operand_a_i = 16'($urandom);
      operand_b_i = 16'($urandom);
      dma_step_i = 1'b1;
      cyc();
      dma_step_i = 1'b0;
      accm = cfg[7] ? sh(res(), cfg[6], j + 1) : res();
      note(1, accm);
    end
    // Clear must be refused while the datapath belongs to DMA
    wr8(8'h20);
    note(1, accm);
    dma_mode_i = 1'b0;
    // Raise the zero flag, then leave a non-zero accumulator for the clear
    wr8(8'h08);
    op(16'h0000);
    note(4, 40'h1);
    wr8(8'h00);
    op();
    wr8(8'h20);
    note(1, 40'h0);
    note(4, 40'h0);
    note(3, 40'h1);
    note(5, 40'h1);
    rd(8'hC0, 8'h00);
    flag_clr_i = 1'b1;
    cyc();
    flag_clr_i = 1'b0;
    cyc();
    note(3, 40'h0);
    // Mid-run reset must bring the register back to zero
    wr8(8'h5B);
    rst_n_i = 1'b0;
    cyc();
    rst_n_i = 1'b1;
    repeat (3) cyc();
    rd(8'hC0, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
